// ### verilog/calendar_clock_pkg.sv
// Constants, register map and types shared by the calendar clock register set.
package calendar_clock_pkg;

  // Register offsets, used as printed on the register port.
  localparam logic [15:0] ADDR_NET_POLICY = 16'h60ae;
  localparam logic [15:0] ADDR_HOURS      = 16'h60b0;
  localparam logic [15:0] ADDR_MINUTES    = 16'h60b2;
  localparam logic [15:0] ADDR_SECONDS    = 16'h60b4;
  localparam logic [15:0] ADDR_SUMMER     = 16'h60b6;
  localparam logic [15:0] ADDR_YEAR       = 16'h60b8;
  localparam logic [15:0] ADDR_MONTH      = 16'h60ba;
  localparam logic [15:0] ADDR_DAY        = 16'h60bc;
  localparam logic [15:0] ADDR_ZONE       = 16'h60be;

  // Network time policy encodings.
  localparam logic [1:0] POLICY_OFF     = 2'h0;
  localparam logic [1:0] POLICY_TRUSTED = 2'h1;
  localparam logic [1:0] POLICY_ANY     = 2'h2;
  localparam logic [1:0] POLICY_RESET   = POLICY_OFF;

  // Field limits.
  localparam logic [4:0]  HOUR_MAX   = 5'h17;
  localparam logic [5:0]  MINUTE_MAX = 6'h3b;
  localparam logic [5:0]  SECOND_MAX = 6'h3b;
  localparam logic [11:0] YEAR_MIN   = 12'h7e1;
  localparam logic [11:0] YEAR_MAX   = 12'h81f;
  localparam logic [3:0]  MONTH_MAX  = 4'hc;
  localparam logic [4:0]  DAY_MAX    = 5'h1f;
  localparam logic [15:0] ZONE_LIMIT = 16'h0348;
  localparam int          SUMMER_SHIFT_MIN = 60;
  localparam int          MIN_PER_HOUR     = 60;
  localparam int          MIN_PER_DAY      = 1440;

  // Reset values of the running clock, the staging fields and the zone offset.
  localparam logic [11:0] RST_YEAR   = YEAR_MIN;
  localparam logic [3:0]  RST_MONTH  = 4'h1;
  localparam logic [4:0]  RST_DAY    = 5'h01;
  localparam logic [4:0]  RST_HOUR   = 5'h00;
  localparam logic [5:0]  RST_MINUTE = 6'h00;
  localparam logic [5:0]  RST_SECOND = 6'h00;
  localparam logic [15:0] RST_ZONE   = 16'h0000;

  // Timing: one second at the 125 MHz core clock.
  localparam int SECOND_NS     = 1_000_000_000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
  } clock_time_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage : calendar_clock_pkg

// ### verilog/wrap_counter.sv
// Loadable modulo counter used for seconds, minutes and hours.
module wrap_counter
  import calendar_clock_pkg::*;
#(
  parameter int              WIDTH     = 6,
  parameter logic [WIDTH-1:0] MAX_VAL  = '1,
  parameter logic [WIDTH-1:0] RST_VAL  = '0
) (
  input  wire logic             clk_i,      // Core clock.
  input  wire logic             resetn_i,   // Asynchronous reset, active low.
  input  wire logic             inc_i,      // Advance by one.
  input  wire logic             load_i,     // Load has priority over advance.
  input  wire logic [WIDTH-1:0] load_val_i, // Value to load.
  output logic      [WIDTH-1:0] value_o,    // Current count.
  output logic                  wrap_o      // Advance that wraps to zero.
);

  logic [WIDTH-1:0] count_ff;

  assign value_o = count_ff;
  assign wrap_o  = inc_i && !load_i && (count_ff >= MAX_VAL);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_ff <= RST_VAL;
    end else if (load_i) begin
      count_ff <= load_val_i;
    end else if (inc_i) begin
      count_ff <= (count_ff >= MAX_VAL) ? '0 : count_ff + 1'b1;
    end
  end

endmodule : wrap_counter

// ### verilog/month_length.sv
// Number of days in a given month, with leap years of the supported span.
module month_length
  import calendar_clock_pkg::*;
(
  input  wire logic [11:0] year_i,  // Full year.
  input  wire logic [3:0]  month_i, // Month 1 to 12.
  output logic      [4:0]  days_o   // Days in that month.
);

  // Every fourth year is a leap year across the whole supported span.
  always_comb begin
    case (month_i)
      4'h2:    days_o = (year_i[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4,
      4'h6,
      4'h9,
      4'hb:    days_o = 5'h1e;
      default: days_o = DAY_MAX;
    endcase
  end

endmodule : month_length

// ### verilog/calendar_clock_register_set.sv
// Calendar clock with staged holding registers, network time and battery restore.
module calendar_clock_register_set
  import calendar_clock_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SECOND_CYCLES
) (
  input  wire logic        CLK_I,          // Core clock, 125 MHz.
  input  wire logic        RESETN_I,       // Asynchronous reset, active low.
  input  wire reg_req_t    REG_REQ_I,      // Register port request.
  output logic      [31:0] REG_RDATA_O,    // Read data.
  output logic             REG_RVALID_O,   // Read data valid pulse.
  input  wire logic        ETH_LINK_I,     // Ethernet link up pin.
  input  wire logic        NTP_VALID_I,    // Network time packet pulse.
  input  wire logic        NTP_TRUSTED_I,  // Packet from a trusted server.
  input  wire clock_time_t NTP_UTC_I,      // UTC time carried by the packet.
  input  wire logic        BATT_PRESENT_I, // Backup battery fitted pin.
  input  wire logic        BKP_VALID_I,    // Preserved time valid pin.
  input  wire clock_time_t BKP_TIME_I,     // Preserved battery clock value.
  output clock_time_t      CLOCK_TIME_O,   // Running local time.
  output logic             SUMMER_TIME_O   // Summer flag in effect.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and boot restore.

  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic [1:0] boot_cnt_ff;
  logic       link_up;
  logic       boot_load;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else begin
      pin_meta_ff <= {ETH_LINK_I, BATT_PRESENT_I, BKP_VALID_I};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign link_up = pin_sync_ff[2];

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      boot_cnt_ff <= 2'h0;
    end else if (boot_cnt_ff != 2'h3) begin
      boot_cnt_ff <= boot_cnt_ff + 2'h1;
    end
  end

  // Battery state is judged once, after the synchronisers have settled.
  assign boot_load = (boot_cnt_ff == 2'h2) && pin_sync_ff[1] && pin_sync_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode, configuration and staging.

  logic [1:0]  net_policy_ff;
  logic [15:0] zone_ff;
  logic        summer_ff;
  logic        stage_summer_ff;
  clock_time_t stage_ff;
  clock_time_t snap_ff;
  clock_time_t now;
  logic        wr_hit;
  logic        commit;
  logic [31:0] wd;

  assign wd     = REG_REQ_I.wdata;
  assign wr_hit = REG_REQ_I.wr;
  assign commit = wr_hit && (REG_REQ_I.addr == ADDR_DAY);

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      net_policy_ff <= POLICY_RESET;
    end else if (wr_hit && REG_REQ_I.addr == ADDR_NET_POLICY) begin
      net_policy_ff <= (wd > 32'(POLICY_ANY)) ? POLICY_ANY : wd[1:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      zone_ff <= RST_ZONE;
    end else if (wr_hit && REG_REQ_I.addr == ADDR_ZONE) begin
      if ($signed(wd[15:0]) > $signed(ZONE_LIMIT)) begin
        zone_ff <= ZONE_LIMIT;
      end else if ($signed(wd[15:0]) < -$signed(ZONE_LIMIT)) begin
        zone_ff <= 16'h0 - ZONE_LIMIT;
      end else begin
        zone_ff <= wd[15:0];
      end
    end
  end

  // Staged fields collect single or multiple writes until the day write.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stage_ff        <= '{RST_YEAR, RST_MONTH, RST_DAY, RST_HOUR, RST_MINUTE, RST_SECOND};
      stage_summer_ff <= 1'b0;
    end else if (wr_hit) begin
      case (REG_REQ_I.addr)
        ADDR_HOURS:   stage_ff.hour   <= 5'(clamp(wd, 32'h0, 32'(HOUR_MAX)));
        ADDR_MINUTES: stage_ff.minute <= 6'(clamp(wd, 32'h0, 32'(MINUTE_MAX)));
        ADDR_SECONDS: stage_ff.second <= 6'(clamp(wd, 32'h0, 32'(SECOND_MAX)));
        ADDR_SUMMER:  stage_summer_ff <= wd[0];
        ADDR_YEAR:    stage_ff.year   <= 12'(clamp(wd, 32'(YEAR_MIN), 32'(YEAR_MAX)));
        ADDR_MONTH:   stage_ff.month  <= 4'(clamp(wd, 32'h1, 32'(MONTH_MAX)));
        ADDR_DAY:     stage_ff.day    <= 5'(clamp(wd, 32'h1, 32'(DAY_MAX)));
        default:      stage_ff        <= stage_ff;
      endcase
    end
  end

  // Only a register write moves the summer flag; nothing switches it by date.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      summer_ff <= 1'b0;
    end else if (commit) begin
      summer_ff <= stage_summer_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Network time to local time.

  logic        ntp_take;
  logic signed [17:0] tot;
  logic [4:0]  dim_utc;
  logic [4:0]  dim_prev;
  logic [3:0]  prev_month;
  logic [11:0] prev_year;
  clock_time_t ntp_local;

  assign ntp_take = NTP_VALID_I && link_up &&
                    ((net_policy_ff == POLICY_ANY) ||
                     ((net_policy_ff == POLICY_TRUSTED) && NTP_TRUSTED_I));

  assign prev_month = (NTP_UTC_I.month <= 4'h1) ? MONTH_MAX : NTP_UTC_I.month - 4'h1;
  assign prev_year  = (NTP_UTC_I.month <= 4'h1) ? NTP_UTC_I.year - 12'h1 : NTP_UTC_I.year;

  month_length u_len_utc (
    .year_i  (NTP_UTC_I.year),
    .month_i (NTP_UTC_I.month),
    .days_o  (dim_utc)
  );

  month_length u_len_prev (
    .year_i  (prev_year),
    .month_i (prev_month),
    .days_o  (dim_prev)
  );

  always_comb begin
    ntp_local = NTP_UTC_I;
    tot = $signed(18'(NTP_UTC_I.hour) * 18'(MIN_PER_HOUR) + 18'(NTP_UTC_I.minute))
        + $signed({{2{zone_ff[15]}}, zone_ff})
        + (summer_ff ? 18'(SUMMER_SHIFT_MIN) : 18'h0);
    if (tot < 0) begin
      tot = tot + 18'(MIN_PER_DAY);
      if (NTP_UTC_I.day <= 5'h1) begin
        ntp_local.day   = dim_prev;
        ntp_local.month = prev_month;
        ntp_local.year  = prev_year;
      end else begin
        ntp_local.day = NTP_UTC_I.day - 5'h1;
      end
    end else if (tot >= 18'(MIN_PER_DAY)) begin
      tot = tot - 18'(MIN_PER_DAY);
      if (NTP_UTC_I.day >= dim_utc) begin
        ntp_local.day = 5'h1;
        if (NTP_UTC_I.month >= MONTH_MAX) begin
          ntp_local.month = 4'h1;
          ntp_local.year  = NTP_UTC_I.year + 12'h1;
        end else begin
          ntp_local.month = NTP_UTC_I.month + 4'h1;
        end
      end else begin
        ntp_local.day = NTP_UTC_I.day + 5'h1;
      end
    end
    ntp_local.hour   = 5'(tot / 18'(MIN_PER_HOUR));
    ntp_local.minute = 6'(tot % 18'(MIN_PER_HOUR));
    ntp_local.year   = 12'(clamp(32'(ntp_local.year), 32'(YEAR_MIN), 32'(YEAR_MAX)));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Running clock.

  logic [26:0] tick_cnt_ff;
  logic        tick;
  logic        load;
  clock_time_t load_val;
  logic        sec_wrap;
  logic        min_wrap;
  logic        hour_wrap;
  logic [11:0] year_ff;
  logic [3:0]  month_ff;
  logic [4:0]  day_ff;
  logic [4:0]  dim_now;

  assign tick = (tick_cnt_ff == 27'(SEC_CYCLES_P - 1));

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tick_cnt_ff <= 27'h0;
    end else if (tick || commit) begin
      tick_cnt_ff <= 27'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 27'h1;
    end
  end

  // A register commit wins over a network update, which wins over restore.
  always_comb begin
    load     = commit || ntp_take || boot_load;
    load_val = BKP_TIME_I;
    if (commit) begin
      load_val     = stage_ff;
      load_val.day = 5'(clamp(wd, 32'h1, 32'(DAY_MAX)));
    end else if (ntp_take) begin
      load_val = ntp_local;
    end
  end

  wrap_counter #(.WIDTH(6), .MAX_VAL(SECOND_MAX), .RST_VAL(RST_SECOND)) u_sec (
    .clk_i      (CLK_I),
    .resetn_i   (RESETN_I),
    .inc_i      (tick),
    .load_i     (load),
    .load_val_i (load_val.second),
    .value_o    (now.second),
    .wrap_o     (sec_wrap)
  );

  wrap_counter #(.WIDTH(6), .MAX_VAL(MINUTE_MAX), .RST_VAL(RST_MINUTE)) u_min (
    .clk_i      (CLK_I),
    .resetn_i   (RESETN_I),
    .inc_i      (sec_wrap),
    .load_i     (load),
    .load_val_i (load_val.minute),
    .value_o    (now.minute),
    .wrap_o     (min_wrap)
  );

  wrap_counter #(.WIDTH(5), .MAX_VAL(HOUR_MAX), .RST_VAL(RST_HOUR)) u_hour (
    .clk_i      (CLK_I),
    .resetn_i   (RESETN_I),
    .inc_i      (min_wrap),
    .load_i     (load),
    .load_val_i (load_val.hour),
    .value_o    (now.hour),
    .wrap_o     (hour_wrap)
  );

  month_length u_len_now (
    .year_i  (year_ff),
    .month_i (month_ff),
    .days_o  (dim_now)
  );

  // The year wraps back to the start of the span after its last day.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      year_ff  <= RST_YEAR;
      month_ff <= RST_MONTH;
      day_ff   <= RST_DAY;
    end else if (load) begin
      year_ff  <= load_val.year;
      month_ff <= load_val.month;
      day_ff   <= load_val.day;
    end else if (hour_wrap) begin
      if (day_ff >= dim_now) begin
        day_ff <= 5'h1;
        if (month_ff >= MONTH_MAX) begin
          month_ff <= 4'h1;
          year_ff  <= (year_ff >= YEAR_MAX) ? YEAR_MIN : year_ff + 12'h1;
        end else begin
          month_ff <= month_ff + 4'h1;
        end
      end else begin
        day_ff <= day_ff + 5'h1;
      end
    end
  end

  assign now.year  = year_ff;
  assign now.month = month_ff;
  assign now.day   = day_ff;

  assign CLOCK_TIME_O  = now;
  assign SUMMER_TIME_O = summer_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot and read data.

  logic hours_rd;

  assign hours_rd = REG_REQ_I.rd && (REG_REQ_I.addr == ADDR_HOURS);

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      snap_ff <= '{RST_YEAR, RST_MONTH, RST_DAY, RST_HOUR, RST_MINUTE, RST_SECOND};
    end else if (hours_rd) begin
      snap_ff <= now;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O  <= 32'h0;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_REQ_I.rd;
      if (REG_REQ_I.rd) begin
        case (REG_REQ_I.addr)
          ADDR_NET_POLICY: REG_RDATA_O <= 32'(net_policy_ff);
          ADDR_HOURS:      REG_RDATA_O <= 32'(now.hour);
          ADDR_MINUTES:    REG_RDATA_O <= 32'(snap_ff.minute);
          ADDR_SECONDS:    REG_RDATA_O <= 32'(snap_ff.second);
          ADDR_SUMMER:     REG_RDATA_O <= 32'(summer_ff);
          ADDR_YEAR:       REG_RDATA_O <= 32'(snap_ff.year);
          ADDR_MONTH:      REG_RDATA_O <= 32'(snap_ff.month);
          ADDR_DAY:        REG_RDATA_O <= 32'(snap_ff.day);
          ADDR_ZONE:       REG_RDATA_O <= {{16{zone_ff[15]}}, zone_ff};
          default:         REG_RDATA_O <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  AST_HOUR_RANGE:   assert property (CLOCK_TIME_O.hour <= HOUR_MAX) else $error("hour out of range");
  AST_MINUTE_RANGE: assert property (CLOCK_TIME_O.minute <= MINUTE_MAX) else $error("minute out of range");
  AST_SECOND_RANGE: assert property (CLOCK_TIME_O.second <= SECOND_MAX) else $error("second out of range");
  AST_YEAR_RANGE:   assert property (!boot_load |=> CLOCK_TIME_O.year inside {[YEAR_MIN:YEAR_MAX]})
                      else $error("year out of range");
  AST_MONTH_RANGE:  assert property (!boot_load |=> CLOCK_TIME_O.month inside {[1:12]})
                      else $error("month out of range");
  AST_DAY_RANGE:    assert property (!boot_load |=> CLOCK_TIME_O.day inside {[1:31]})
                      else $error("day out of range");
  AST_SNAPSHOT:     assert property (hours_rd |=> snap_ff == $past(now))
                      else $error("hours read did not refresh record");
  AST_COMMIT:       assert property (commit |=> CLOCK_TIME_O.hour == $past(stage_ff.hour)
                                     && CLOCK_TIME_O.minute == $past(stage_ff.minute)
                                     && SUMMER_TIME_O == $past(stage_summer_ff))
                      else $error("day write did not commit staged time");
  AST_POLICY:       assert property (ntp_take |-> net_policy_ff != POLICY_OFF && link_up)
                      else $error("network time taken while disallowed");
  AST_TRUSTED:      assert property (ntp_take && net_policy_ff == POLICY_TRUSTED |-> NTP_TRUSTED_I)
                      else $error("untrusted server accepted");
  AST_UTC_PASS:     assert property (ntp_take && !commit && zone_ff == 16'h0 && !summer_ff
                                     |=> CLOCK_TIME_O.minute == $past(NTP_UTC_I.minute)
                                     && CLOCK_TIME_O.hour == $past(NTP_UTC_I.hour))
                      else $error("zero offset did not show UTC");
  AST_SUMMER_SHIFT: assert property (ntp_take && !commit && zone_ff == 16'h0 && summer_ff
                                     && NTP_UTC_I.hour < HOUR_MAX
                                     |=> CLOCK_TIME_O.hour == $past(NTP_UTC_I.hour) + 5'h1)
                      else $error("summer shift not applied");
  AST_SUMMER_HOLD:  assert property (!commit |=> $stable(SUMMER_TIME_O))
                      else $error("summer flag changed without write");
  AST_SEC_STEP:     assert property (tick && !load && CLOCK_TIME_O.second < SECOND_MAX
                                     |=> CLOCK_TIME_O.second == $past(CLOCK_TIME_O.second) + 6'h1)
                      else $error("second did not advance");

endmodule : calendar_clock_register_set

// ### tb/ntp_source.sv
// Network side model: Ethernet link pin and network time packets.
module ntp_source
  import calendar_clock_pkg::*;
(
  input  wire logic  clk_i,     // Core clock.
  output logic       link_o,    // Ethernet link up.
  output logic       valid_o,   // Packet pulse.
  output logic       trusted_o, // Packet from a trusted server.
  output clock_time_t utc_o     // UTC carried by the packet.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    link_o    = 1'b0;
    valid_o   = 1'b0;
    trusted_o = 1'b0;
    utc_o     = '0;
  end

  task automatic set_link(input logic up);
    @(posedge clk_i);
    link_o <= up;
    repeat (4) @(posedge clk_i);
  endtask : set_link

  // Outside a packet the time lines show the inverse, never a stale value.
  task automatic send(input logic tr, input clock_time_t t);
    @(posedge clk_i);
    valid_o   <= 1'b1;
    trusted_o <= tr;
    utc_o     <= t;
    @(posedge clk_i);
    valid_o   <= 1'b0;
    trusted_o <= ~tr;
    utc_o     <= ~t;
    @(posedge clk_i);
  endtask : send
endmodule : ntp_source

// ### tb/testbench.sv
// Register, network time and battery restore tests of the calendar clock.
module testbench
  import calendar_clock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, resetn, batt, bkp_valid, rvalid, summer, link, nvalid, ntrust;
  reg_req_t    req;
  logic [31:0] rdata, rd;
  clock_time_t bkp_time, now, utc;
  int          fail_count, n_compared, i;
  logic [31:0] pol_in [4] = '{32'h0, 32'h1, 32'h2, 32'h5};
  logic [31:0] pol_ex [4] = '{32'h0, 32'h1, 32'h2, 32'h2};

  calendar_clock_register_set #(.SEC_CYCLES_P(10)) i_dut (
    .CLK_I(clk), .RESETN_I(resetn), .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .ETH_LINK_I(link), .NTP_VALID_I(nvalid), .NTP_TRUSTED_I(ntrust), .NTP_UTC_I(utc),
    .BATT_PRESENT_I(batt), .BKP_VALID_I(bkp_valid), .BKP_TIME_I(bkp_time),
    .CLOCK_TIME_O(now), .SUMMER_TIME_O(summer));

  ntp_source i_ntp (.clk_i(clk), .link_o(link), .valid_o(nvalid), .trusted_o(ntrust), .utc_o(utc));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chkt(input clock_time_t got, input clock_time_t exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: time %h, expected %h", $time, got, exp);
    end
  endtask : chkt

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : reg_wr

  // Read data is taken one cycle after the request edge, with its valid pulse.
  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1;
    chk32({31'h0, rvalid}, 32'h1);
    d = rdata;
  endtask : reg_rd

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    reg_rd(a, rd);
    chk32(rd, exp);
  endtask : rd_chk

  task automatic ntp_chk(input logic tr, input logic [4:0] h, input logic [4:0] exp_h);
    i_ntp.send(tr, '{year: 12'h7e1, month: 4'h1, day: 5'h01, hour: h, minute: 6'h1e, second: 6'h05});
    #1;
    chk32({27'h0, now.hour}, {27'h0, exp_h});
  endtask : ntp_chk

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    n_compared = 0;
    resetn = 1'b0;
    req = '0;
    batt = 1'b0;
    bkp_valid = 1'b0;
    bkp_time = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(ADDR_NET_POLICY, 32'h0);
    chkt(now, '{12'h7e1, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00});
    rd_chk(16'h60a0, 32'h0);
    $display("test reset done");
    // Supervisor sets the clock after power-up with out-of-range values.
    reg_wr(ADDR_HOURS, 32'h1e);
    reg_wr(ADDR_MINUTES, 32'h46);
    reg_wr(ADDR_SECONDS, 32'h63);
    reg_wr(ADDR_SUMMER, 32'h1);
    reg_wr(ADDR_YEAR, 32'hbb8);
    reg_wr(ADDR_MONTH, 32'hf);
    chk32({31'h0, summer}, 32'h0);
    reg_wr(ADDR_DAY, 32'h28);
    chkt(now, '{12'h81f, 4'hc, 5'h1f, 5'h17, 6'h3b, 6'h3b});
    rd_chk(ADDR_HOURS, 32'h17);
    rd_chk(ADDR_MINUTES, 32'h3b);
    rd_chk(ADDR_SUMMER, 32'h1);
    i = 0;
    while (now.second === 6'h3b && i < 40) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 40) begin
      fail_count++;
      finish_test();
    end
    chkt(now, '{12'h7e1, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00});
    rd_chk(ADDR_MINUTES, 32'h3b);
    rd_chk(ADDR_HOURS, 32'h0);
    rd_chk(ADDR_MINUTES, 32'h0);
    $display("test commit done");
    for (int k = 0; k < 4; k++) begin
      reg_wr(ADDR_NET_POLICY, pol_in[k]);
      rd_chk(ADDR_NET_POLICY, pol_ex[k]);
    end
    reg_wr(ADDR_ZONE, 32'h3c);
    ntp_chk(1'b0, 5'h03, 5'h00);
    i_ntp.set_link(1'b1);
    reg_wr(ADDR_NET_POLICY, 32'h1);
    ntp_chk(1'b0, 5'h05, 5'h00);
    ntp_chk(1'b1, 5'h06, 5'h08);
    reg_wr(ADDR_NET_POLICY, 32'h2);
    ntp_chk(1'b0, 5'h0c, 5'h0e);
    chk32({26'h0, now.minute}, 32'h1e);
    reg_wr(ADDR_NET_POLICY, 32'h0);
    ntp_chk(1'b1, 5'h01, 5'h0e);
    chk32({31'h0, summer}, 32'h1);
    reg_wr(ADDR_ZONE, 32'h0);
    reg_wr(ADDR_NET_POLICY, 32'h2);
    ntp_chk(1'b0, 5'h05, 5'h06);
    reg_wr(ADDR_SUMMER, 32'h0);
    reg_wr(ADDR_DAY, 32'h1);
    ntp_chk(1'b0, 5'h03, 5'h03);
    $display("test network done");
    @(posedge clk);
    resetn <= 1'b0;
    batt <= 1'b1;
    bkp_valid <= 1'b1;
    bkp_time <= '{12'h7e4, 4'h2, 5'h1d, 5'h0a, 6'h14, 6'h1e};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chkt(now, '{12'h7e4, 4'h2, 5'h1d, 5'h0a, 6'h14, 6'h1e});
    $display("test battery done");
    finish_test();
  end
endmodule : testbench
